// ==== imu_params.svh ====
`ifndef IMU_PARAMS_SVH
`define IMU_PARAMS_SVH
`define IMU_OP_ID        8'h02
`define IMU_OP_STATUS    8'h03
`define IMU_OP_PROG      8'h04
`define IMU_OP_USER      8'h05
`define IMU_OP_CFG_NVRD  8'h25
`define IMU_OP_CFG_LO    8'h31
`define IMU_OP_CFG_HI    8'h35
`define IMU_OP_TRIM_LO   8'h41
`define IMU_OP_TRIM_HI   8'h44
`define IMU_OP_MEAS_WR   8'h51
`define IMU_OP_MEAS_RD   8'h52
`define IMU_OP_TAG_LO    8'h61
`define IMU_OP_TAG_HI    8'h65
`define IMU_OP_LOG_ERASE 8'h71
`define IMU_OP_LOG_LO    8'h73
`define IMU_OP_LOG_HI    8'h76
`define IMU_KEY_LO       8'h3d
`define IMU_KEY_HI       8'he5
`define IMU_ADDR_HI_DEF  4'hc
`define IMU_ST_CRC       7
`define IMU_ST_CFG_DONE  6
`define IMU_ST_SA_DONE   5
`define IMU_ST_PROG      4
`define IMU_ST_REFRESH   2
`define IMU_ST_ERASE     0
`define IMU_ST_PGM       15
`define IMU_ST_LOG_CLR   14
`define IMU_ST_LOG_WR    13
`define IMU_ST_LOG_FULL  12
`define IMU_ST_ROW_LSB   8
`endif

// ==== imu_pkg.sv ====
`default_nettype none
package imu_pkg;
    typedef enum logic [3:0] {
        IMU_GRP_NONE, IMU_GRP_ID, IMU_GRP_STATUS, IMU_GRP_PROG, IMU_GRP_USER,
        IMU_GRP_CFG, IMU_GRP_TRIM, IMU_GRP_MEAS, IMU_GRP_TAG, IMU_GRP_LOG
    } imu_grp_t;
    typedef struct packed {
        logic       valid;
        imu_grp_t   grp;
        logic [7:0] code;
    } imu_cmd_t;
    typedef struct packed {
        logic       crc_fail;
        logic       cfg_done;
        logic       sa_done;
        logic       refresh;
        logic       erase_busy;
        logic       prog_busy;
        logic       log_clearing;
        logic       log_writing;
        logic       log_full;
        logic [3:0] row_index;
    } imu_stat_in_t;
endpackage
`default_nettype wire

// ==== imu_unit.sv ====
// Operation
// - first write byte is instruction code
// - 0x02..0x05 id, status, prog, user
// - 0x25, 0x31..0x35 config memory group
// - 0x41..0x44 trim setpoint writes
// - 0x51 measurement write, 0x52 read
// - 0x61..0x65 user tag operations
// - 0x71, 0x73..0x76 fault log group
// - identity read returns one id byte
// - status read low byte then high
// - b7 crc fail, cleared on boot-write
// - b6 b5 done flags after programming
// - b4 programming mode, b3 b1 zero
// - b2 refresh, clears after status high byte read
// - b0 erase busy, b15 program busy
// - b14 log/tag clearing, b13 log writing
// - b12 fault log full
// - b11..b8 last programmed log row
// - 0x04 plus key 0xe53d enters programming
// - 0x05 with no data byte returns to user mode
// - device acks address, code, data
// - read uses repeated start after code
// - address is 4 config bits plus strap
`timescale 1ns/100ps
`default_nettype none
`include "imu_params.svh"
module imu_unit
    import imu_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5a  // arbitrary value
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    // i2c pins
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe_o,
    // address sources
    input  wire logic [3:0]   addr_hi_i,
    input  wire logic         addr_hi_valid_i,
    input  wire logic [2:0]   addr_strap_i,
    // status sources and boot-write start
    input  wire imu_stat_in_t stat_i,
    input  wire logic         boot_write_start_i,
    // decoded command and programming mode flag out
    output imu_cmd_t          cmd_o,
    output logic              programming_state_flag_o
);
    logic rst_s1_q, rst_n_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // two-stage pin sync, then edge history
    logic [1:0] scl_s_q, sda_s_q;
    logic       scl_q, sda_q;
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_q   <= scl_s_q[1];
            sda_q   <= sda_s_q[1];
        end
    end
    wire scl = scl_s_q[1];
    wire sda = sda_s_q[1];
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    wire start_c  = scl & scl_q & sda_q & ~sda;
    wire stop_c   = scl & scl_q & ~sda_q & sda;

    function automatic imu_grp_t decode(input logic [7:0] c);
        imu_grp_t g;
        g = IMU_GRP_NONE;
        if (c == `IMU_OP_ID) g = IMU_GRP_ID;
        else if (c == `IMU_OP_STATUS) g = IMU_GRP_STATUS;
        else if (c == `IMU_OP_PROG) g = IMU_GRP_PROG;
        else if (c == `IMU_OP_USER) g = IMU_GRP_USER;
        else if (c == `IMU_OP_CFG_NVRD ||
                 (c >= `IMU_OP_CFG_LO && c <= `IMU_OP_CFG_HI)) g = IMU_GRP_CFG;
        else if (c >= `IMU_OP_TRIM_LO && c <= `IMU_OP_TRIM_HI) g = IMU_GRP_TRIM;
        else if (c == `IMU_OP_MEAS_WR || c == `IMU_OP_MEAS_RD) g = IMU_GRP_MEAS;
        else if (c >= `IMU_OP_TAG_LO && c <= `IMU_OP_TAG_HI) g = IMU_GRP_TAG;
        else if (c == `IMU_OP_LOG_ERASE ||
                 (c >= `IMU_OP_LOG_LO && c <= `IMU_OP_LOG_HI)) g = IMU_GRP_LOG;
        return g;
    endfunction

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WBYTE, S_RBYTE, S_RACK, S_IGNORE} imu_st_t;
    imu_st_t    st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic       rd_q, ack_ok_q;
    logic [1:0] byte_q;       // write bytes after address
    logic [7:0] op_q;
    logic [7:0] key_lo_q;
    logic [1:0] rd_idx_q;
    logic       prog_q;

    wire [6:0] own_addr = {addr_hi_valid_i ? addr_hi_i : `IMU_ADDR_HI_DEF,
                           addr_strap_i};

    logic        crc_q, refresh_q;
    logic [15:0] status_w;
    always_comb begin
        status_w = 16'h0000;  // b3 b1 stay zero
        status_w[`IMU_ST_CRC]      = crc_q;
        status_w[`IMU_ST_CFG_DONE] = stat_i.cfg_done;
        status_w[`IMU_ST_SA_DONE]  = stat_i.sa_done;
        status_w[`IMU_ST_PROG]     = prog_q;
        status_w[`IMU_ST_REFRESH]  = refresh_q;
        status_w[`IMU_ST_ERASE]    = stat_i.erase_busy;
        status_w[`IMU_ST_PGM]      = stat_i.prog_busy;
        status_w[`IMU_ST_LOG_CLR]  = stat_i.log_clearing;
        status_w[`IMU_ST_LOG_WR]   = stat_i.log_writing;
        status_w[`IMU_ST_LOG_FULL] = stat_i.log_full;
        status_w[`IMU_ST_ROW_LSB +: 4] = stat_i.row_index;
    end

    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'hff;  // no meaningful data
        if (op_q == `IMU_OP_ID && rd_idx_q == 2'd0) rd_byte = ID_CODE;
        else if (op_q == `IMU_OP_STATUS && rd_idx_q == 2'd0) rd_byte = status_w[7:0];
        else if (op_q == `IMU_OP_STATUS && rd_idx_q == 2'd1) rd_byte = status_w[15:8];
    end

    wire wbyte_done = (st_q == S_WBYTE) && scl_rise && bit_q == 4'd7;
    wire [7:0] wbyte = {sh_q[6:0], sda};

    // byte framing
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= S_IDLE;
            bit_q <= 4'd0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            ack_ok_q <= 1'b0;
        end else if (start_c) begin
            st_q <= S_ADDR;  // repeated start keeps op
            bit_q <= 4'd0;
        end else if (stop_c) begin
            st_q <= S_IDLE;
        end else if (scl_rise) begin
            case (st_q)
                S_ADDR, S_WBYTE: begin
                    sh_q <= wbyte;
                    bit_q <= bit_q + 4'd1;
                    if (bit_q == 4'd7) begin
                        if (st_q == S_ADDR) begin
                            rd_q <= sda;
                            ack_ok_q <= (sh_q[6:0] == own_addr);
                            st_q <= (sh_q[6:0] == own_addr) ? S_ACK : S_IGNORE;
                        end else begin
                            ack_ok_q <= 1'b1;
                            st_q <= S_ACK;
                        end
                    end
                end
                S_RBYTE: begin
                    bit_q <= bit_q + 4'd1;
                    if (bit_q == 4'd7) st_q <= S_RACK;
                end
                S_RACK: begin
                    bit_q <= 4'd0;
                    st_q <= sda ? S_IGNORE : S_RBYTE;  // master nack ends read
                end
                S_ACK: begin
                    bit_q <= 4'd0;
                    st_q <= rd_q ? S_RBYTE : S_WBYTE;
                end
                default: ;
            endcase
        end
    end

    // write byte sequencing, code capture, mode key
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            byte_q <= 2'd0;
            op_q <= 8'h00;
            key_lo_q <= 8'h00;
            prog_q <= 1'b0;
            cmd_o <= '0;
        end else begin
            cmd_o.valid <= 1'b0;
            if (start_c && !rd_q) byte_q <= 2'd0;
            if (st_q == S_ADDR && scl_rise && bit_q == 4'd7 && !sda) byte_q <= 2'd0;
            if (wbyte_done) begin
                if (byte_q != 2'd3) byte_q <= byte_q + 2'd1;
                if (byte_q == 2'd0) begin
                    op_q <= wbyte;
                    cmd_o.valid <= 1'b1;
                    cmd_o.code <= wbyte;
                    cmd_o.grp <= decode(wbyte);
                end else if (op_q == `IMU_OP_PROG && byte_q == 2'd1) begin
                    key_lo_q <= wbyte;
                end else if (op_q == `IMU_OP_PROG && byte_q == 2'd2 &&
                             key_lo_q == `IMU_KEY_LO && wbyte == `IMU_KEY_HI) begin
                    prog_q <= 1'b1;  // key must match
                end
            end
            if (stop_c && op_q == `IMU_OP_USER && byte_q == 2'd1) prog_q <= 1'b0;
        end
    end
    assign programming_state_flag_o = prog_q;

    // status flags; set wins over clear
    wire status_hi_read = st_q == S_RBYTE && scl_rise && bit_q == 4'd7 &&
                          op_q == `IMU_OP_STATUS && rd_idx_q == 2'd1;
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            crc_q <= 1'b0;
            refresh_q <= 1'b0;
        end else begin
            if (stat_i.crc_fail) crc_q <= 1'b1;
            else if (boot_write_start_i) crc_q <= 1'b0;
            if (stat_i.refresh) refresh_q <= 1'b1;
            else if (status_hi_read) refresh_q <= 1'b0;
        end
    end

    // read index and sda drive
    always_ff @(posedge core_clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_idx_q <= 2'd0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            if (start_c) rd_idx_q <= 2'd0;
            else if (st_q == S_RACK && scl_rise && rd_idx_q != 2'd3) rd_idx_q <= rd_idx_q + 2'd1;
            if (scl_fall) begin
                sda_o <= 1'b0;
                sda_oe_o <= 1'b0;
                if (st_q == S_ACK && ack_ok_q) sda_oe_o <= 1'b1;
                else if (st_q == S_RBYTE && !rd_byte[3'd7 - bit_q[2:0]]) sda_oe_o <= 1'b1;
            end
            if (start_c || stop_c) sda_oe_o <= 1'b0;
        end
    end

    property p_unlock;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        $rose(prog_q) |-> $past(op_q) == `IMU_OP_PROG && key_lo_q == `IMU_KEY_LO;
    endproperty
    a_unlock: assert property (p_unlock) else $error("programming_state_flag without key");
    property p_user;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        $fell(prog_q) |-> $past(op_q) == `IMU_OP_USER;
    endproperty
    a_user: assert property (p_user) else $error("user mode on wrong code");
    property p_mode_bit;
        @(posedge core_clk_i) disable iff (!rst_n_q) status_w[`IMU_ST_PROG] == programming_state_flag_o;
    endproperty
    a_mode_bit: assert property (p_mode_bit) else $error("mode bit mismatch");
    property p_resv;
        @(posedge core_clk_i) disable iff (!rst_n_q) status_w[3] == 1'b0 && status_w[1] == 1'b0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved status bit set");
    property p_reserved_code;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        cmd_o.valid && cmd_o.code == 8'h72 |-> cmd_o.grp == IMU_GRP_NONE;
    endproperty
    a_reserved_code: assert property (p_reserved_code) else $error("reserved code decoded");
    property p_refresh_clr;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        status_hi_read && !stat_i.refresh |=> !refresh_q;
    endproperty
    a_refresh_clr: assert property (p_refresh_clr) else $error("refresh not cleared");
    property p_crc_set;
        @(posedge core_clk_i) disable iff (!rst_n_q) stat_i.crc_fail |=> crc_q;
    endproperty
    a_crc_set: assert property (p_crc_set) else $error("crc flag lost");
    property p_code_capture;
        @(posedge core_clk_i) disable iff (!rst_n_q) cmd_o.valid |-> cmd_o.code == op_q;
    endproperty
    a_code_capture: assert property (p_code_capture) else $error("code not captured");
    property p_trim;
        @(posedge core_clk_i) disable iff (!rst_n_q)
        cmd_o.valid && cmd_o.code == `IMU_OP_TRIM_HI |-> cmd_o.grp == IMU_GRP_TRIM;
    endproperty
    a_trim: assert property (p_trim) else $error("trim code misdecoded");
    c_unlock: cover property (@(posedge core_clk_i) disable iff (!rst_n_q) $rose(prog_q));
    c_user: cover property (@(posedge core_clk_i) disable iff (!rst_n_q) $fell(prog_q));
    c_status: cover property (@(posedge core_clk_i) disable iff (!rst_n_q) status_hi_read);
endmodule
`default_nettype wire

// ==== imu_master.sv ====
`timescale 1ns/100ps
`default_nettype none
// i2c master model; scl rests high between frames
module imu_master (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    localparam realtime Q = 31.25;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // long low phase gives the slave time to let go of sda
    task automatic start();
        sda_oe_o = 1'b0;
        #(2*Q) scl_o = 1'b1;
        #Q sda_oe_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_oe_o = 1'b0;
        #(2*Q);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_oe_o = ~b;
        #Q scl_o = 1'b1;
        #Q r = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // ack low on all but the last byte, then release for nack
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(~ack, r);
    endtask
endmodule
`default_nettype wire

// ==== imu_unit_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module imu_unit_tb_top;
    import imu_pkg::*;
    localparam logic [7:0] ID = 8'h3c; // arbitrary value
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         scl, m_oe, d_oe, d_o, prog;
    logic         bws = 1'b0;
    logic         hv = 1'b1;
    logic [3:0]   ahi = 4'ha;
    logic [2:0]   strap = 3'h5;
    logic [6:0]   sa = 7'h55;
    logic [15:0]  v;
    imu_stat_in_t st = '0;
    imu_cmd_t     cmd, last;
    int           num_errors = 0;
    int           n_tests = 0;
    wire          sda = ~(m_oe | d_oe);
    always #5 clk = ~clk;
    always @(posedge clk) if (cmd.valid === 1'b1) last <= cmd;
    imu_master m_u (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    imu_unit #(.ID_CODE(ID)) dut_u (
        .core_clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
        .sda_oe_o(d_oe), .addr_hi_i(ahi), .addr_hi_valid_i(hv), .addr_strap_i(strap),
        .stat_i(st), .boot_write_start_i(bws), .cmd_o(cmd), .programming_state_flag_o(prog)
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] q[$], input logic ack_exp);
        logic a;
        m_u.start();
        m_u.wr_byte({sa, 1'b0}, a);
        chk(a, ack_exp, "addr ack");
        if (a) foreach (q[i]) begin
            m_u.wr_byte(q[i], a);
            chk(a, 1'b1, "byte ack");
        end
        m_u.stop();
    endtask
    task automatic rd(input logic [7:0] code, input int n, output logic [15:0] r);
        logic a;
        r = '0;
        m_u.start();
        m_u.wr_byte({sa, 1'b0}, a);
        m_u.wr_byte(code, a);
        m_u.start();
        m_u.wr_byte({sa, 1'b1}, a);
        chk(a, 1'b1, "read addr ack");
        for (int i = 0; i < n; i++) m_u.rd_byte(i < n - 1, r[8*i +: 8]);
        m_u.stop();
    endtask
    task automatic pulse_bws();
        @(posedge clk) #1 bws = 1'b1;
        @(posedge clk) #1 bws = 1'b0;
    endtask
    task automatic t_decode();
        logic [7:0] c[] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h24, 8'h25, 8'h26, 8'h30,
            8'h31, 8'h33, 8'h35, 8'h36, 8'h41, 8'h44, 8'h45, 8'h51, 8'h52, 8'h53, 8'h61,
            8'h65, 8'h66, 8'h71, 8'h72, 8'h73, 8'h76, 8'h77};
        imu_grp_t g[] = '{IMU_GRP_NONE, IMU_GRP_ID, IMU_GRP_STATUS, IMU_GRP_USER,
            IMU_GRP_NONE, IMU_GRP_NONE, IMU_GRP_CFG, IMU_GRP_NONE, IMU_GRP_NONE,
            IMU_GRP_CFG, IMU_GRP_CFG, IMU_GRP_CFG, IMU_GRP_NONE, IMU_GRP_TRIM,
            IMU_GRP_TRIM, IMU_GRP_NONE, IMU_GRP_MEAS, IMU_GRP_MEAS, IMU_GRP_NONE,
            IMU_GRP_TAG, IMU_GRP_TAG, IMU_GRP_NONE, IMU_GRP_LOG, IMU_GRP_NONE,
            IMU_GRP_LOG, IMU_GRP_LOG, IMU_GRP_NONE};
        foreach (c[i]) begin
            wr('{c[i]}, 1'b1);
            chk(last.code, c[i], "code");
            chk(last.grp, g[i], "group");
        end
        $display("test decode done");
    endtask
    task automatic t_prog();
        wr('{8'h04, 8'h3d, 8'he4}, 1'b1);
        chk(prog, 1'b0, "wrong key");
        wr('{8'h04, 8'he5, 8'h3d}, 1'b1);
        chk(prog, 1'b0, "swapped key");
        wr('{8'h04, 8'h3d, 8'he5}, 1'b1);
        chk(last.grp, IMU_GRP_PROG, "prog group");
        chk(prog, 1'b1, "programming_state_flag");
        rd(8'h03, 2, v);
        chk(v, 16'h0010, "status in prog");
        wr('{8'h05, 8'h00}, 1'b1);
        chk(prog, 1'b1, "user with data");
        wr('{8'h05}, 1'b1);
        chk(prog, 1'b0, "user mode");
        rd(8'h03, 2, v);
        chk(v, 16'h0000, "status in user");
        $display("test prog done");
    endtask
    task automatic t_status();
        @(posedge clk) #1 st = '{1, 1, 0, 1, 1, 0, 1, 0, 1, 4'h9};
        @(posedge clk) #1 st = '{0, 1, 0, 0, 1, 0, 1, 0, 1, 4'h9};
        rd(8'h03, 2, v);
        chk(v, 16'h59c5, "status");
        rd(8'h03, 2, v);
        chk(v, 16'h59c1, "refresh cleared");
        pulse_bws();
        rd(8'h03, 2, v);
        chk(v, 16'h5941, "crc cleared");
        @(posedge clk) #1 st = '{0, 0, 1, 0, 0, 1, 0, 1, 0, 4'hf};
        rd(8'h03, 2, v);
        chk(v, 16'haf20, "status busy");
        $display("test status done");
    endtask
    task automatic t_addr();
        rd(8'h02, 1, v);
        chk(v[7:0], ID, "id");
        rd(8'h06, 1, v);
        chk(v[7:0], 8'hff, "reserved read");
        @(posedge clk) #1 hv = 1'b0;
        wr('{8'h02}, 1'b0);
        sa = {4'hc, strap};
        rd(8'h02, 1, v);
        chk(v[7:0], ID, "default upper");
        @(posedge clk) #1 strap = 3'h2;
        sa = {4'hc, 3'h2};
        rd(8'h02, 1, v);
        chk(v[7:0], ID, "strap");
        chk(d_o, 1'b0, "open drain level");
        $display("test addr done");
    endtask
    task automatic results();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge clk);
        t_decode();
        t_prog();
        t_status();
        t_addr();
        results();
    end
    // run needs about 150 us
    initial begin
        #600us;
        num_errors++;
        results();
    end
endmodule
`default_nettype wire
